// ---- design/vm_entry_pkg.sv ----
// Purpose: Shared constants for the entry check unit.
// Assumes: AHB-Lite word registers, byte offsets below.
// Notes:   Control bit positions follow the execution controls.
package vm_entry_pkg;
    // ==========================================================
    // States
    typedef enum logic [1:0] {ST_IDLE, ST_BASIC, ST_CTRL} st_type;

    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] OFF_CMD    = 8'h00;
    localparam logic [7:0] OFF_CPU    = 8'h04;
    localparam logic [7:0] OFF_PIN    = 8'h08;
    localparam logic [7:0] OFF_PROC   = 8'h0C;
    localparam logic [7:0] OFF_PROC2  = 8'h10;
    localparam logic [7:0] OFF_EXITC  = 8'h14;
    localparam logic [7:0] OFF_CR3N   = 8'h18;
    localparam logic [7:0] OFF_TPRTH  = 8'h1C;
    localparam logic [7:0] OFF_VIRTUAL_TASK_PRIORITY_REG   = 8'h20;
    localparam logic [7:0] OFF_PIVEC  = 8'h24;
    localparam logic [7:0] OFF_VIRTUAL_PROCESSOR_IDENTIFIER   = 8'h28;
    localparam logic [7:0] OFF_VMFN   = 8'h2C;
    localparam logic [7:0] OFF_ASEL   = 8'h30;
    localparam logic [7:0] OFF_ALO    = 8'h34;
    localparam logic [7:0] OFF_AHI    = 8'h38;
    localparam logic [7:0] OFF_CAP    = 8'h3C;
    localparam logic [7:0] OFF_PIN_F1 = 8'h40;
    localparam logic [7:0] OFF_PIN_A1 = 8'h44;
    localparam logic [7:0] OFF_PRO_F1 = 8'h48;
    localparam logic [7:0] OFF_PRO_A1 = 8'h4C;
    localparam logic [7:0] OFF_SEC_A1 = 8'h50;
    localparam logic [7:0] OFF_FN_A1  = 8'h54;
    localparam logic [7:0] OFF_LAUNCH = 8'h58;

    // ==========================================================
    // Field positions
    localparam int CMD_GO = 0, CMD_RESUME = 1;
    localparam int CPU_V86 = 0, CPU_COMPAT = 1, CPU_CPL = 2;
    localparam int CPU_PRESENT = 4, CPU_SS_BLK = 5;
    localparam int PIN_EXT_INT = 0, PIN_NMI_EXIT = 3;
    localparam int PIN_VNMI = 5, PIN_POSTED = 7;
    localparam int PRI_TPR = 21, PRI_NMI_WIN = 22;
    localparam int PRI_IO = 25, PRI_MSR = 28, PRI_SEC = 31;
    localparam int SEC_APIC_ACC = 0, SEC_NPG = 1, SEC_X2 = 4;
    localparam int SEC_VIRTUAL_PROCESSOR_IDENTIFIER = 5, SEC_UNRESTR = 7, SEC_ARV = 8;
    localparam int SEC_VID = 9, SEC_VMFN = 13;
    localparam int EXIT_ACK = 15, VMFN_PTR_SW = 0;
    localparam int CAP_ADDR32 = 0, CAP_AD = 1;
    localparam int CAP_MT = 8, CAP_PAW = 16;
    localparam int STS_DONE = 0, STS_PASS = 1, STS_UD = 2;
    localparam int STS_GP = 3, STS_CF = 4, STS_ZF = 5;
    localparam int STS_LAUNCHED = 6, STS_ERR = 8, STS_CAUSE = 16;

    // ==========================================================
    // Address slots, limits, codes, reset values
    localparam logic [2:0] AI_IO_A = 3'h0, AI_IO_B = 3'h1;
    localparam logic [2:0] AI_MSR = 3'h2, AI_VAPIC = 3'h3;
    localparam logic [2:0] AI_APIC = 3'h4, AI_PI = 3'h5;
    localparam logic [2:0] AI_NPTP = 3'h6, AI_PLIST = 3'h7;
    localparam logic [31:0] CR3_MAX   = 32'h0000_0004;
    localparam logic [2:0]  WALK_4    = 3'h3;
    localparam logic [63:0] PAGE_LOW  = 64'h0000_0000_0000_0FFF;
    localparam logic [63:0] PI_LOW    = 64'h0000_0000_0000_003F;
    localparam logic [7:0]  ERR_SS    = 8'h01;
    localparam logic [7:0]  ERR_LAUNCH = 8'h02;
    localparam logic [7:0]  ERR_RESUME = 8'h03;
    localparam logic [7:0]  ERR_CTRL  = 8'h04;
    localparam logic [31:0] CAP_RST   = 32'h0024_4000;
    localparam int          NFAIL     = 19;
endpackage

// ---- design/vm_entry_check_unit.sv ----
// Purpose: Decides whether a guest entry instruction may proceed.
// Assumes: Single AHB-Lite slave, zero wait states, word access.
// Notes:   Check starts on a CMD write; result two cycles later, three if basic checks pass.
//
// Our own choices: the AHB-Lite interface to the registers and the register offsets.

// Function
// [RULE1] Mode check first: invalid opcode fault
// [RULE2] Nonzero privilege level: general protection fault
// [RULE3] No structure loaded: set carry, continue
// [RULE4] Ordered: blocking, launch state, resume state
// [RULE5] Structure check fail: zero flag, error number
// [RULE6] Control checks only after basic checks pass
// [RULE7] Pin and primary reserved bits match capability
// [RULE8] Secondary gated by bit 31, reserved clear
// [RULE9] Target count above four fails entry
// [RULE10] Enabled page addresses need bits 11:0 zero
// [RULE11] Addresses within width, 32-bit limit option
// [RULE12] Shadow on, early checks pass: clear bytes
// [RULE13] Threshold bits 31:4 zero without delivery
// [RULE14] Threshold low nibble not above priority
// [RULE15] Virtual NMI control dependencies enforced
// [RULE16] Shadow off forbids controller extensions
// [RULE17] Posted interrupts need delivery, ack, alignment
// [RULE18] Enabled identifier must not be zero
// [RULE19] Pointer memory type supported, walk three
// [RULE20] Pointer dirty bit, reserved, width checks
// [RULE21] Unrestricted guest requires nested paging
// [RULE22] Function controls checked only when enabled
// [RULE23] Passing first entry marks structure launched
// [RULE24] One result with prioritised cause code
module vm_entry_check_unit
    import vm_entry_pkg::*;
(
    input  wire logic        hclk,      // Bus clock
    input  wire logic        hresetn,   // Async reset
    input  wire logic        hsel,      // Slave select
    input  wire logic [31:0] haddr,     // Address
    input  wire logic [1:0]  htrans,    // Transfer type
    input  wire logic        hwrite,    // Write
    input  wire logic [2:0]  hsize,     // Size, word only
    input  wire logic [31:0] hwdata,    // Write data
    input  wire logic        hready,    // Bus ready
    output logic      [31:0] hrdata,    // Read data
    output logic             hreadyout, // Always ready
    output logic             hresp,     // Always OKAY
    output logic             result_valid, // Check done pulse
    output logic             entry_pass,   // Entry may proceed
    output logic             invalid_opcode,     // Fault
    output logic             general_protection, // Fault
    output logic             carry_flag,   // Flag result
    output logic             zero_flag     // Flag result
);
    import vm_entry_pkg::*;

    // ==========================================================
    // State
    typedef struct packed {
        st_type            st;
        logic              resume;
        logic              wr_pend;
        logic [7:0]        waddr;
        logic [31:0]       rdata;
        logic [5:0]        cpu;
        logic [31:0]       pin;
        logic [31:0]       proc;
        logic [31:0]       proc2;
        logic [31:0]       exitc;
        logic [31:0]       cr3n;
        logic [31:0]       tprth;
        logic [31:0]       virtual_task_priority_reg;
        logic [31:0]       vmfn;
        logic [15:0]       pivec;
        logic [15:0]       virtual_processor_identifier;
        logic [2:0]        asel;
        logic [7:0][63:0]  addr;
        logic [31:0]       cap;
        logic [31:0]       pin_f1;
        logic [31:0]       pin_a1;
        logic [31:0]       pro_f1;
        logic [31:0]       pro_a1;
        logic [31:0]       sec_a1;
        logic [31:0]       fn_a1;
        logic              launched;
        logic              done;
        logic              pass;
        logic              ud;
        logic              gp;
        logic              cf;
        logic              zf;
        logic [7:0]        err;
        logic [4:0]        cause;
    } state_type;

    state_type s_q, s_d;

    // ==========================================================
    // Helpers
    function automatic logic addr_bad(input logic [63:0] a,
                                      input logic [63:0] low,
                                      input logic [31:0] cap);
        logic wide;
        wide = (a >> cap[CAP_PAW +: 8]) != 64'h0;
        return (|(a & low)) || wide ||
               (cap[CAP_ADDR32] && (|a[63:32]));
    endfunction

    function automatic logic rsv_bad(input logic [31:0] v,
                                     input logic [31:0] f1,
                                     input logic [31:0] a1);
        return ((v & f1) != f1) || ((v & ~a1) != 32'h0);
    endfunction

    // ==========================================================
    // Decoded controls
    logic [31:0]      sec;
    logic             task_priority, vid, acc, npg, vnmi;
    logic [63:0]      nptp;
    logic [NFAIL-1:0] fail;
    logic             mode_bad, cpl_bad, basic_ok;
    logic             wr_now, go_now, rd_req;

    assign sec  = s_q.proc[PRI_SEC] ? s_q.proc2 : 32'h0; // RULE8
    assign task_priority  = s_q.proc[PRI_TPR];
    assign vid  = sec[SEC_VID];
    assign acc  = sec[SEC_APIC_ACC];
    assign npg  = sec[SEC_NPG];
    assign vnmi = s_q.pin[PIN_VNMI];
    assign nptp = s_q.addr[AI_NPTP];

    assign mode_bad = s_q.cpu[CPU_V86] || s_q.cpu[CPU_COMPAT];
    assign cpl_bad  = s_q.cpu[CPU_CPL +: 2] != 2'h0;
    assign basic_ok = !mode_bad && !cpl_bad &&
                      s_q.cpu[CPU_PRESENT] &&
                      !s_q.cpu[CPU_SS_BLK] &&
                      !(!s_q.resume && s_q.launched) &&
                      !(s_q.resume && !s_q.launched);

    always_comb begin
        fail = '0;
        fail[0] = rsv_bad(s_q.pin, s_q.pin_f1, s_q.pin_a1); // RULE7
        fail[1] = rsv_bad(s_q.proc, s_q.pro_f1,
                          s_q.pro_a1); // RULE7
        fail[2] = |(sec & ~s_q.sec_a1); // RULE8
        fail[3] = s_q.cr3n > CR3_MAX; // RULE9
        fail[4] = s_q.proc[PRI_IO] && // RULE10 RULE11
                  (addr_bad(s_q.addr[AI_IO_A], PAGE_LOW, s_q.cap) ||
                   addr_bad(s_q.addr[AI_IO_B], PAGE_LOW, s_q.cap));
        fail[5] = s_q.proc[PRI_MSR] && // RULE10 RULE11
                  addr_bad(s_q.addr[AI_MSR], PAGE_LOW, s_q.cap);
        fail[6] = task_priority && // RULE10 RULE11
                  addr_bad(s_q.addr[AI_VAPIC], PAGE_LOW, s_q.cap);
        fail[7] = task_priority && !vid && (|s_q.tprth[31:4]); // RULE13
        fail[8] = task_priority && !acc && !vid && // RULE14
                  (s_q.tprth[3:0] > s_q.virtual_task_priority_reg[7:4]);
        fail[9] = (vnmi && !s_q.pin[PIN_NMI_EXIT]) || // RULE15
                  (s_q.proc[PRI_NMI_WIN] && !vnmi);
        fail[10] = acc && // RULE10 RULE11
                   addr_bad(s_q.addr[AI_APIC], PAGE_LOW, s_q.cap);
        fail[11] = !task_priority && // RULE16
                   (sec[SEC_X2] || sec[SEC_ARV] || vid);
        fail[12] = sec[SEC_X2] && acc; // RULE16
        fail[13] = vid && !s_q.pin[PIN_EXT_INT]; // RULE16
        fail[14] = s_q.pin[PIN_POSTED] && // RULE17
                   (!vid || !s_q.exitc[EXIT_ACK] ||
                    (|s_q.pivec[15:8]) ||
                    addr_bad(s_q.addr[AI_PI], PI_LOW, s_q.cap));
        fail[15] = sec[SEC_VIRTUAL_PROCESSOR_IDENTIFIER] && s_q.virtual_processor_identifier == 16'h0000; // RULE18
        fail[16] = npg && // RULE19 RULE20
                   (!s_q.cap[CAP_MT + {29'h0, nptp[2:0]}] ||
                    nptp[5:3] != WALK_4 ||
                    (nptp[6] && !s_q.cap[CAP_AD]) ||
                    (|nptp[11:7]) ||
                    addr_bad(nptp, 64'h0, 32'h0 |
                             {8'h0, s_q.cap[CAP_PAW +: 8], 16'h0}));
        fail[17] = sec[SEC_UNRESTR] && !npg; // RULE21
        fail[18] = sec[SEC_VMFN] && // RULE22
                   ((|(s_q.vmfn & ~s_q.fn_a1)) ||
                    (s_q.vmfn[VMFN_PTR_SW] && (!npg ||
                     addr_bad(s_q.addr[AI_PLIST], PAGE_LOW,
                              s_q.cap))));
    end

    // ==========================================================
    // Bus decode
    assign wr_now = s_q.wr_pend;
    assign go_now = wr_now && s_q.waddr == OFF_CMD &&
                    hwdata[CMD_GO];
    assign rd_req = hsel && htrans[1] && hready && !hwrite;

    function automatic logic [31:0] rd_mux(input state_type s,
                                           input logic [7:0] a);
        logic [31:0] r;
        r = 32'h0;
        unique case (a)
            OFF_CMD: begin
                r[STS_DONE]     = s.done;
                r[STS_PASS]     = s.pass;
                r[STS_UD]       = s.ud;
                r[STS_GP]       = s.gp;
                r[STS_CF]       = s.cf;
                r[STS_ZF]       = s.zf;
                r[STS_LAUNCHED] = s.launched;
                r[STS_ERR +: 8]   = s.err;
                r[STS_CAUSE +: 5] = s.cause;
            end
            OFF_CPU:    r = {26'h0, s.cpu};
            OFF_PIN:    r = s.pin;
            OFF_PROC:   r = s.proc;
            OFF_PROC2:  r = s.proc2;
            OFF_EXITC:  r = s.exitc;
            OFF_CR3N:   r = s.cr3n;
            OFF_TPRTH:  r = s.tprth;
            OFF_VIRTUAL_TASK_PRIORITY_REG:   r = s.virtual_task_priority_reg;
            OFF_PIVEC:  r = {16'h0, s.pivec};
            OFF_VIRTUAL_PROCESSOR_IDENTIFIER:   r = {16'h0, s.virtual_processor_identifier};
            OFF_VMFN:   r = s.vmfn;
            OFF_ASEL:   r = {29'h0, s.asel};
            OFF_ALO:    r = s.addr[s.asel][31:0];
            OFF_AHI:    r = s.addr[s.asel][63:32];
            OFF_CAP:    r = s.cap;
            OFF_PIN_F1: r = s.pin_f1;
            OFF_PIN_A1: r = s.pin_a1;
            OFF_PRO_F1: r = s.pro_f1;
            OFF_PRO_A1: r = s.pro_a1;
            OFF_SEC_A1: r = s.sec_a1;
            OFF_FN_A1:  r = s.fn_a1;
            OFF_LAUNCH: r = {31'h0, s.launched};
            default:    r = 32'h0;
        endcase
        return r;
    endfunction

    // ==========================================================
    // Next state
    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        s_d.wr_pend = hsel && htrans[1] && hready && hwrite;
        s_d.waddr = haddr[7:0];
        if (rd_req) begin
            s_d.rdata = rd_mux(s_q, haddr[7:0]);
        end
        if (wr_now) begin
            unique case (s_q.waddr)
                OFF_CPU:    s_d.cpu    = hwdata[5:0];
                OFF_PIN:    s_d.pin    = hwdata;
                OFF_PROC:   s_d.proc   = hwdata;
                OFF_PROC2:  s_d.proc2  = hwdata;
                OFF_EXITC:  s_d.exitc  = hwdata;
                OFF_CR3N:   s_d.cr3n   = hwdata;
                OFF_TPRTH:  s_d.tprth  = hwdata;
                OFF_VIRTUAL_TASK_PRIORITY_REG:   s_d.virtual_task_priority_reg   = hwdata;
                OFF_PIVEC:  s_d.pivec  = hwdata[15:0];
                OFF_VIRTUAL_PROCESSOR_IDENTIFIER:   s_d.virtual_processor_identifier   = hwdata[15:0];
                OFF_VMFN:   s_d.vmfn   = hwdata;
                OFF_ASEL:   s_d.asel   = hwdata[2:0];
                OFF_ALO:    s_d.addr[s_q.asel][31:0]  = hwdata;
                OFF_AHI:    s_d.addr[s_q.asel][63:32] = hwdata;
                OFF_CAP:    s_d.cap    = hwdata;
                OFF_PIN_F1: s_d.pin_f1 = hwdata;
                OFF_PIN_A1: s_d.pin_a1 = hwdata;
                OFF_PRO_F1: s_d.pro_f1 = hwdata;
                OFF_PRO_A1: s_d.pro_a1 = hwdata;
                OFF_SEC_A1: s_d.sec_a1 = hwdata;
                OFF_FN_A1:  s_d.fn_a1  = hwdata;
                OFF_LAUNCH: s_d.launched = 1'b0;
                default: ;
            endcase
        end
        unique case (s_q.st)
            ST_IDLE: begin
                // Go while busy is dropped, not queued
                if (go_now) begin
                    s_d.st     = ST_BASIC;
                    s_d.resume = hwdata[CMD_RESUME];
                    s_d.pass = 1'b0;
                    s_d.ud = 1'b0;
                    s_d.gp = 1'b0;
                    s_d.cf = 1'b0;
                    s_d.zf = 1'b0;
                    s_d.err = 8'h00;
                    s_d.cause = 5'h00;
                end
            end
            ST_BASIC: begin
                s_d.st = ST_IDLE;
                s_d.done = 1'b1;
                if (mode_bad) begin
                    s_d.ud = 1'b1; // RULE1
                end else if (cpl_bad) begin
                    s_d.gp = 1'b1; // RULE2
                end else if (!s_q.cpu[CPU_PRESENT]) begin
                    s_d.cf = 1'b1; // RULE3
                end else if (s_q.cpu[CPU_SS_BLK]) begin
                    s_d.zf = 1'b1; // RULE4 RULE5
                    s_d.err = ERR_SS;
                end else if (!s_q.resume && s_q.launched) begin
                    s_d.zf = 1'b1; // RULE4 RULE5
                    s_d.err = ERR_LAUNCH;
                end else if (s_q.resume && !s_q.launched) begin
                    s_d.zf = 1'b1; // RULE4 RULE5
                    s_d.err = ERR_RESUME;
                end else begin
                    s_d.st = ST_CTRL; // RULE6
                    s_d.done = 1'b0;
                end
            end
            ST_CTRL: begin
                s_d.st = ST_IDLE;
                s_d.done = 1'b1;
                // Clearing wins over a same-cycle software write
                if (task_priority && fail[6:0] == 7'h0) begin
                    s_d.virtual_task_priority_reg[31:8] = 24'h0; // RULE12
                end
                if (|fail) begin
                    s_d.zf = 1'b1; // RULE6
                    s_d.err = ERR_CTRL;
                    for (int i = NFAIL - 1; i >= 0; i--) begin
                        if (fail[i]) begin
                            s_d.cause = 5'(i); // RULE24
                        end
                    end
                end else begin
                    s_d.pass = 1'b1;
                    if (!s_q.resume) begin
                        s_d.launched = 1'b1; // RULE23
                    end
                end
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q <= '0;
            s_q.st <= ST_IDLE;
            s_q.cap <= CAP_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // Outputs
    assign hrdata             = s_q.rdata;
    assign hreadyout          = 1'b1;
    assign hresp              = 1'b0;
    assign result_valid       = s_q.done;
    assign entry_pass         = s_q.pass;
    assign invalid_opcode     = s_q.ud;
    assign general_protection = s_q.gp;
    assign carry_flag         = s_q.cf;
    assign zero_flag          = s_q.zf;

    // ==========================================================
    // Assertions
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_start;
        s_q.st == ST_IDLE && go_now;
    endsequence
    sequence s_basic_pass;
        s_q.st == ST_BASIC && basic_ok;
    endsequence

    a_ud_mode: assert property ( // RULE1
        s_q.st == ST_BASIC && mode_bad |=>
        s_q.done && s_q.ud && !s_q.gp && !s_q.cf)
        else $error("mode fault missing");
    a_gp_level: assert property ( // RULE2
        s_q.st == ST_BASIC && !mode_bad && cpl_bad |=>
        s_q.done && s_q.gp && !s_q.ud)
        else $error("privilege fault missing");
    a_cf_absent: assert property ( // RULE3
        s_q.st == ST_BASIC && !mode_bad && !cpl_bad &&
        !s_q.cpu[CPU_PRESENT] |=> s_q.cf && !s_q.zf)
        else $error("carry not set");
    a_ss_order: assert property ( // RULE4
        s_q.st == ST_BASIC && !mode_bad && !cpl_bad &&
        s_q.cpu[CPU_PRESENT] && s_q.cpu[CPU_SS_BLK] |=>
        s_q.zf && s_q.err == ERR_SS)
        else $error("blocking error wrong");
    a_launch_state: assert property ( // RULE5
        s_q.st == ST_BASIC && !mode_bad && !cpl_bad &&
        s_q.cpu[CPU_PRESENT] && !s_q.cpu[CPU_SS_BLK] &&
        s_q.resume && !s_q.launched |=>
        s_q.zf && s_q.err == ERR_RESUME)
        else $error("resume error wrong");
    a_ctrl_after: assert property ( // RULE6
        s_start ##1 s_basic_pass |=> s_q.st == ST_CTRL)
        else $error("control stage skipped");
    a_ctrl_fail: assert property ( // RULE6
        s_q.st == ST_CTRL && (|fail) |=>
        s_q.zf && s_q.err == ERR_CTRL && !s_q.pass)
        else $error("control failure lost");
    a_count_limit: assert property ( // RULE9
        s_q.st == ST_CTRL && s_q.cr3n > CR3_MAX |=> !s_q.pass)
        else $error("count limit ignored");
    a_virtual_task_priority_reg_clear: assert property ( // RULE12
        s_q.st == ST_CTRL && task_priority && fail[6:0] == 7'h0 |=>
        s_q.virtual_task_priority_reg[31:8] == 24'h0)
        else $error("priority bytes kept");
    a_launch_mark: assert property ( // RULE23
        s_q.st == ST_CTRL && !(|fail) && !s_q.resume |=>
        s_q.launched && s_q.pass)
        else $error("launch state not set");
    a_one_result: assert property ( // RULE24
        s_start |-> ##1 (s_q.st == ST_BASIC) ##[1:2] s_q.done)
        else $error("no result in time");
endmodule

// ---- verif/tb_vm_entry_check_unit.sv ----
// Purpose: Self-checking bench for the entry check unit.
// Assumes: Zero-wait AHB-Lite slave; capability may-be-1 opened wide.
// Notes:   Launch state is tracked inside the expected status words.
module tb_vm_entry_check_unit;
    timeunit 1ns;
    timeprecision 1ps;
    import vm_entry_pkg::*;

    // ==========================================================
    // Signals
    logic        hclk, hresetn, hsel, hwrite;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        hreadyout, hresp, result_valid, entry_pass;
    logic        invalid_opcode, general_protection;
    logic        carry_flag, zero_flag;
    int          err_count, num_checks;

    vm_entry_check_unit dut_u (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp),
        .result_valid(result_valid), .entry_pass(entry_pass),
        .invalid_opcode(invalid_opcode),
        .general_protection(general_protection),
        .carry_flag(carry_flag), .zero_flag(zero_flag)
    );

    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end

    // ==========================================================
    // Tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk(r, e);
        chk({31'h0, hresp}, 32'h0);
    endtask

    // Cause field only meaningful on a control failure
    task automatic run(input logic [31:0] cmd, input logic [31:0] cpu,
                       input logic [31:0] e);
        logic [31:0] r;
        logic [31:0] m;
        logic        seen;
        seen = 1'b0;
        m = (e[15:8] == ERR_CTRL) ? 32'h001F_FF7E : 32'h0000_FF7E;
        wr(OFF_CPU, cpu);
        wr(OFF_CMD, cmd);
        for (int i = 0; i < 6 && !seen; i++) begin
            @(posedge hclk);
            #1;
            seen = (result_valid === 1'b1);
        end
        chk({26'h0, zero_flag, carry_flag, general_protection,
             invalid_opcode, entry_pass, seen}, {26'h0, e[5:1], 1'b1});
        bus(1'b0, OFF_CMD, 32'h0, r);
        chk(r & m, e);
    endtask

    task automatic print_verdict();
        if (err_count == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ==========================================================
    // Tests
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        err_count = 0;
        num_checks = 0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        rd(OFF_CAP, 32'h0024_4000);
        rd(OFF_LAUNCH, 32'h0);
        wr(8'h80, 32'hFFFF_FFFF);
        rd(8'h80, 32'h0);
        wr(OFF_PIN_A1, 32'hFFFF_FFFF);
        wr(OFF_PRO_A1, 32'hFFFF_FFFF);
        wr(OFF_SEC_A1, 32'hFFFF_FFFF);
        wr(OFF_FN_A1, 32'hFFFF_FFFF);
        run(32'h1, 32'h0F, 32'h04);
        run(32'h1, 32'h02, 32'h04);
        run(32'h1, 32'h1C, 32'h08);
        run(32'h1, 32'h00, 32'h10);
        run(32'h3, 32'h30, 32'h120);
        run(32'h3, 32'h10, 32'h320);
        wr(OFF_CR3N, 32'h5);
        run(32'h1, 32'h10, 32'h3_0420);
        wr(OFF_CR3N, 32'h4);
        run(32'h1, 32'h10, 32'h42);
        run(32'h1, 32'h10, 32'h260);
        run(32'h3, 32'h10, 32'h42);
        wr(OFF_PROC, 32'h8000_0000);
        wr(OFF_PROC2, 32'hA0);
        wr(OFF_CR3N, 32'h5);
        run(32'h3, 32'h10, 32'h3_0460);
        wr(OFF_CR3N, 32'h0);
        run(32'h3, 32'h10, 32'hF_0460);
        wr(OFF_PROC2, 32'h80);
        run(32'h3, 32'h10, 32'h11_0460);
        wr(OFF_PROC, 32'h0);
        run(32'h3, 32'h10, 32'h42);
        wr(OFF_PROC, 32'h0020_0000);
        wr(OFF_VIRTUAL_TASK_PRIORITY_REG, 32'hFFFF_FFFF);
        wr(OFF_TPRTH, 32'h10);
        run(32'h3, 32'h10, 32'h7_0460);
        rd(OFF_VIRTUAL_TASK_PRIORITY_REG, 32'hFF);
        wr(OFF_TPRTH, 32'hF);
        run(32'h3, 32'h10, 32'h42);
        wr(OFF_VIRTUAL_TASK_PRIORITY_REG, 32'hE0);
        run(32'h3, 32'h10, 32'h8_0460);
        wr(OFF_PROC, 32'h0200_0000);
        wr(OFF_ASEL, 32'h0);
        wr(OFF_ALO, 32'h1);
        run(32'h3, 32'h10, 32'h4_0460);
        wr(OFF_PROC, 32'h0);
        wr(OFF_PIN, 32'h20);
        run(32'h3, 32'h10, 32'h9_0460);
        wr(OFF_PIN, 32'h0);
        wr(OFF_PIN_F1, 32'h1);
        run(32'h3, 32'h10, 32'h0_0460);
        wr(OFF_PIN_F1, 32'h0);
        wr(OFF_PIN, 32'h80);
        run(32'h3, 32'h10, 32'hE_0460);
        wr(OFF_PIN, 32'h0);
        wr(OFF_PROC, 32'h8000_0000);
        wr(OFF_PROC2, 32'h2);
        run(32'h3, 32'h10, 32'h10_0460);
        wr(OFF_PROC, 32'h0200_0000);
        wr(OFF_ALO, 32'h0);
        wr(OFF_AHI, 32'h1);
        run(32'h3, 32'h10, 32'h42);
        wr(OFF_CAP, 32'h0024_4001);
        run(32'h3, 32'h10, 32'h4_0460);
        print_verdict();
    end

    // Whole sequence needs well under a tenth of this span
    initial begin
        #400000;
        err_count++;
        print_verdict();
    end
endmodule
